/* File: design/cse_pkg.sv */
// Shared constants, types and register map of the cylinder seek exerciser.
package cse_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int SRC_TRIG_US      = 4;
  localparam int SRC_TRIG_CYC     = SRC_TRIG_US * CLK_MHZ;
  localparam int READY_DELAY_US   = 10;
  localparam int READY_DELAY_CYC  = READY_DELAY_US * CLK_MHZ;
  localparam int FAST_PERIOD_NS   = 1000;
  localparam int FAST_PERIOD_CYC  = (FAST_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int PULSE_WIDTH_NS   = 200;
  localparam int PULSE_WIDTH_CYC  = (PULSE_WIDTH_NS * CLK_MHZ) / 1000;
  localparam int TIMER_W          = 16;

  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE  = 16'h0001;

  // ---------------------------------------------------------------------------
  // Cylinder counter
  // ---------------------------------------------------------------------------
  localparam int CYL_W = 8;
  localparam logic [CYL_W-1:0] CYL_ZERO   = 8'h00;
  localparam logic [CYL_W-1:0] CYL_ONE    = 8'h01;
  localparam logic [CYL_W-1:0] CYL_TOP    = 8'hca;
  localparam logic [CYL_W-1:0] CYL_MINUS1 = 8'hff;

  // ---------------------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CSE_MODE_STEP = 2'h0,
    CSE_MODE_ALT  = 2'h1,
    CSE_MODE_OSC  = 2'h2,
    CSE_MODE_RAND = 2'h3
  } cse_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_PULSE,
    ST_BUSY
  } cse_strobe_state_t;

  // ---------------------------------------------------------------------------
  // Pin groups
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic               run_switch;
    logic               return_to_zero_switch;
    cse_mode_t          function_sel;
    logic               direction_switch;
    logic [CYL_W-1:0]   panel_cyl;
  } cse_panel_t;

  typedef struct packed {
    logic ready_n;
    logic addr_invalid_n;
    logic seek_fail_in_n;
  } cse_drive_t;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int AVS_ADDR_W = 5;
  localparam logic [AVS_ADDR_W-1:0] REG_CTRL        = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] REG_READY_DELAY = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] REG_FAST_PERIOD = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] REG_PULSE_WIDTH = 5'h0c;
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS      = 5'h10;
  localparam logic [AVS_ADDR_W-1:0] REG_LAST_CYL    = 5'h14;

  localparam int CTRL_STROBE_EN_BIT = 0;
  localparam logic CTRL_STROBE_EN_RST = 1'b1;

  localparam int ST_COUNTER_LSB  = 0;
  localparam int ST_SRC_SEL_BIT  = 8;
  localparam int ST_LC_FLAG_BIT  = 9;
  localparam int ST_LC_LOAD_BIT  = 10;
  localparam int ST_BAD_CYL_BIT  = 11;
  localparam int ST_SEEK_FAIL_BIT = 12;
  localparam int ST_SRC_TRIG_BIT = 13;
  localparam int ST_BUSY_BIT     = 14;

endpackage

/* File: design/cse_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/1ps
module cse_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The reset value is a tie-off constant at every instance.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg ^ reset_val_i;

endmodule

/* File: design/cse_exerciser.sv */
// Cylinder seek exerciser: seek strobe generator, cylinder counter, source select and fault lamps.
//
// Summary of operation
// (RQ1) Run up and drive ready fires seek strobe.
// (RQ2) Drive seeks and withdraws ready on strobe.
// (RQ3) Step mode presents counter, counter advances between.
// (RQ4) Step forward strobe counts up, clears flag.
// (RQ5) Step mode keeps fast clock disabled.
// (RQ6) Reaching 202 clears to 0; next gives 1.
// (RQ7) Alternate reverse decrements on every second strobe.
// (RQ8) Minus one loads 202; next trigger clears flag.
// (RQ9) Oscillate mode holds counter at 0.
// (RQ10) Random mode runs fast clock advancing counter.
// (RQ11) Source trigger inhibits fast clock; strobe adds one.
// (RQ12) Random mode wraps at 202 to 0.
// (RQ13) Return-to-zero holds counter 0, asserts restore.
// (RQ14) Counter spans 0..202 up, 202..-1 down.
// (RQ15) Clear input gives 0, load gives 202.
// (RQ16) Separate detects for 202 and minus one.
// (RQ17) Alternate/oscillate: each seek strobe toggles the source flag; the 4 us trigger does not set it.
// (RQ18) Next strobe resets source flag, selects counter.
// (RQ19) Step/random hold counter source; trigger still fires.
// (RQ20) Address invalid latches lamp until return-to-zero.
// (RQ21) Seek incomplete drives its lamp directly.
// (RQ22) Eight-bit cylinder address gated on each strobe.
// (RQ23) Four modes plus separate direction selector.
// (RQ24) Active-low signals asserted at logic low.
// (RQ25) Ready delay and fast period are cycle counts.
// (RQ26) Inputs synchronised; strobe is registered timed pulse.
`timescale 1ns/1ps
module cse_exerciser (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire cse_pkg::cse_panel_t          panel_i,
  input  wire cse_pkg::cse_drive_t          drive_i,
  output logic                              bus_strobe_n_o,
  output logic      [cse_pkg::CYL_W-1:0]    cyl_addr_o,
  output logic                              restore_n_o,
  output logic                              bad_cylinder_lamp_o,
  output logic                              seek_fail_lamp_o,
  output logic      [cse_pkg::CYL_W-1:0]    counter_value_o,
  input  wire logic [cse_pkg::AVS_ADDR_W-1:0] avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [31:0]                  avs_readdata_o,
  output logic                              avs_waitrequest_o
);
  import cse_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic reg_hit(input logic [AVS_ADDR_W-1:0] addr, input logic [AVS_ADDR_W-1:0] offs);
    reg_hit = (addr == offs);
  endfunction

  function automatic logic [TIMER_W-1:0] merge16(input logic [TIMER_W-1:0] old_val,
                                                  input logic [31:0] wdata, input logic [3:0] be);
    merge16 = {be[1] ? wdata[15:8] : old_val[15:8], be[0] ? wdata[7:0] : old_val[7:0]};
  endfunction

  function automatic logic timer_done(input logic [TIMER_W-1:0] t);
    timer_done = (t <= TIMER_ONE);
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  localparam int PIN_W = $bits(cse_panel_t) + $bits(cse_drive_t);
  // Active-low drive lines idle high, so their synchronised reset value is one.
  localparam logic [PIN_W-1:0] PIN_RESET_XOR = {{$bits(cse_panel_t){1'b0}}, {$bits(cse_drive_t){1'b1}}};

  cse_panel_t       panel_s;
  cse_drive_t       drive_s;
  logic [PIN_W-1:0] pins_s;
  logic [PIN_W-1:0] pins_raw;

  assign pins_raw = {panel_i, drive_i} ^ PIN_RESET_XOR;

  cse_sync #(.WIDTH(PIN_W)) u_sync ( // [RQ26]
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .async_i     (pins_raw),
    .reset_val_i (PIN_RESET_XOR),
    .sync_o      (pins_s)
  );

  assign panel_s = pins_s[PIN_W-1 -: $bits(cse_panel_t)];
  assign drive_s = pins_s[$bits(cse_drive_t)-1:0];

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  logic zero_override_n;
  logic direction_up_n;
  logic direction_down_n;
  logic drive_ready;
  logic step_input;
  logic mode_osc;
  logic mode_rand;

  assign zero_override_n  = ~panel_s.return_to_zero_switch;
  assign direction_up_n   = ~panel_s.direction_switch;                      // [RQ23]
  assign direction_down_n = panel_s.direction_switch;
  assign drive_ready      = ~drive_s.ready_n;                               // [RQ24]
  assign step_input       = (panel_s.function_sel == CSE_MODE_STEP) ||
                            (panel_s.function_sel == CSE_MODE_RAND);         // [RQ23]
  assign mode_osc         = (panel_s.function_sel == CSE_MODE_OSC);
  assign mode_rand        = (panel_s.function_sel == CSE_MODE_RAND);

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  logic               ack_reg;
  logic [31:0]        readdata_reg;
  logic               strobe_en_reg;
  logic [TIMER_W-1:0] ready_delay_reg;
  logic [TIMER_W-1:0] fast_period_reg;
  logic [TIMER_W-1:0] pulse_width_reg;
  logic [31:0]        status_word;
  logic [CYL_W-1:0]   cyl_addr_reg;
  logic               bus_write_go;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_readdata_o    = readdata_reg;
  assign bus_write_go      = avs_write_i & ack_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
      if (avs_read_i && !ack_reg) begin
        if (reg_hit(avs_address_i, REG_CTRL)) begin
          readdata_reg <= {31'h0000_0000, strobe_en_reg};
        end else if (reg_hit(avs_address_i, REG_READY_DELAY)) begin
          readdata_reg <= {16'h0000, ready_delay_reg};
        end else if (reg_hit(avs_address_i, REG_FAST_PERIOD)) begin
          readdata_reg <= {16'h0000, fast_period_reg};
        end else if (reg_hit(avs_address_i, REG_PULSE_WIDTH)) begin
          readdata_reg <= {16'h0000, pulse_width_reg};
        end else if (reg_hit(avs_address_i, REG_STATUS)) begin
          readdata_reg <= status_word;
        end else if (reg_hit(avs_address_i, REG_LAST_CYL)) begin
          readdata_reg <= {24'h00_0000, cyl_addr_reg};
        end else begin
          readdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strobe_en_reg   <= CTRL_STROBE_EN_RST;
      ready_delay_reg <= TIMER_W'(READY_DELAY_CYC);                         // [RQ25]
      fast_period_reg <= TIMER_W'(FAST_PERIOD_CYC);                         // [RQ25]
      pulse_width_reg <= TIMER_W'(PULSE_WIDTH_CYC);                         // [RQ26]
    end else if (bus_write_go) begin
      if (reg_hit(avs_address_i, REG_CTRL) && avs_byteenable_i[0]) begin
        strobe_en_reg <= avs_writedata_i[CTRL_STROBE_EN_BIT];
      end
      if (reg_hit(avs_address_i, REG_READY_DELAY)) begin
        ready_delay_reg <= merge16(ready_delay_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (reg_hit(avs_address_i, REG_FAST_PERIOD)) begin
        fast_period_reg <= merge16(fast_period_reg, avs_writedata_i, avs_byteenable_i);
      end
      if (reg_hit(avs_address_i, REG_PULSE_WIDTH)) begin
        pulse_width_reg <= merge16(pulse_width_reg, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Seek strobe generator
  // ---------------------------------------------------------------------------
  cse_strobe_state_t  strobe_state_reg;
  logic [TIMER_W-1:0] strobe_timer_reg;
  logic               bus_strobe_n_reg;
  logic               seek_fire;

  // One-cycle internal seek pulse at the start of the bus strobe.
  assign seek_fire = (strobe_state_reg == ST_DELAY) && panel_s.run_switch && drive_ready &&
                     timer_done(strobe_timer_reg);                          // [RQ1]

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strobe_state_reg <= ST_IDLE;
      strobe_timer_reg <= TIMER_ZERO;
      bus_strobe_n_reg <= 1'b1;
    end else begin
      case (strobe_state_reg)
        ST_IDLE: begin
          bus_strobe_n_reg <= 1'b1;
          if (panel_s.run_switch && strobe_en_reg && drive_ready) begin
            strobe_state_reg <= ST_DELAY;
            strobe_timer_reg <= ready_delay_reg;                            // [RQ25]
          end
        end
        ST_DELAY: begin
          if (!panel_s.run_switch || !drive_ready) begin
            strobe_state_reg <= ST_IDLE;
          end else if (seek_fire) begin
            strobe_state_reg <= ST_PULSE;
            strobe_timer_reg <= pulse_width_reg;
            bus_strobe_n_reg <= 1'b0;                                       // [RQ1]
          end else begin
            strobe_timer_reg <= strobe_timer_reg - TIMER_ONE;
          end
        end
        ST_PULSE: begin
          if (timer_done(strobe_timer_reg)) begin
            strobe_state_reg <= ST_BUSY;
            bus_strobe_n_reg <= 1'b1;                                       // [RQ26]
          end else begin
            strobe_timer_reg <= strobe_timer_reg - TIMER_ONE;
          end
        end
        ST_BUSY: begin
          // Wait for the drive to drop ready before another strobe.
          if (!drive_ready) begin
            strobe_state_reg <= ST_IDLE;                                    // [RQ2]
          end
        end
        default: begin
          strobe_state_reg <= ST_IDLE;
          bus_strobe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  assign bus_strobe_n_o = bus_strobe_n_reg;

  // ---------------------------------------------------------------------------
  // Address source select
  // ---------------------------------------------------------------------------
  logic [CYL_W-1:0]   counter_value;
  logic               src_flag_reg;
  logic               src_flag_next;
  logic               counter_source_sel;
  logic [TIMER_W-1:0] src_timer_reg;
  logic               source_trigger_n;

  // Outside step and random modes the flag data input is its own inverse, so each strobe toggles it.
  assign src_flag_next      = step_input ? 1'b0 : ~src_flag_reg;           // [RQ17] [RQ18]
  assign counter_source_sel = ~src_flag_reg;
  assign source_trigger_n   = (src_timer_reg == TIMER_ZERO);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      src_flag_reg <= 1'b0;
    end else if (step_input) begin
      src_flag_reg <= 1'b0;                                                 // [RQ19]
    end else if (seek_fire) begin
      src_flag_reg <= src_flag_next;                                        // [RQ17] [RQ18]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      src_timer_reg <= TIMER_ZERO;
    end else if (seek_fire) begin
      src_timer_reg <= TIMER_W'(SRC_TRIG_CYC);                              // [RQ17] [RQ19]
    end else if (!source_trigger_n) begin
      src_timer_reg <= src_timer_reg - TIMER_ONE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cyl_addr_reg <= CYL_ZERO;
    end else if (seek_fire) begin
      // The count before this strobe's step is the one sent out.
      cyl_addr_reg <= src_flag_next ? panel_s.panel_cyl : counter_value;    // [RQ3] [RQ22]
    end
  end

  assign cyl_addr_o = cyl_addr_reg;

  // ---------------------------------------------------------------------------
  // Fast clock
  // ---------------------------------------------------------------------------
  logic [TIMER_W-1:0] fast_timer_reg;
  logic               fast_run;
  logic               fast_tick;

  assign fast_run  = mode_rand && source_trigger_n && !seek_fire && zero_override_n; // [RQ5] [RQ10] [RQ11]
  assign fast_tick = fast_run && timer_done(fast_timer_reg);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fast_timer_reg <= TIMER_ZERO;
    end else if (!fast_run || fast_tick) begin
      fast_timer_reg <= fast_period_reg;                                    // [RQ25]
    end else begin
      fast_timer_reg <= fast_timer_reg - TIMER_ONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Cylinder counter
  // ---------------------------------------------------------------------------
  logic             lc_flag_reg;
  logic             lc_load_reg;
  logic             top_detect;
  logic             minus1_detect;
  logic             strobe_count;
  logic             count_evt;
  logic             zero_hold;

  assign top_detect    = (counter_value == CYL_TOP);                        // [RQ16]
  assign minus1_detect = (counter_value == CYL_MINUS1);                     // [RQ16]
  assign zero_hold     = !zero_override_n || mode_osc;                      // [RQ9] [RQ13]
  // Strobes only step the counter when the counter is the source sent out.
  assign strobe_count  = seek_fire && !src_flag_next && !mode_osc;          // [RQ4] [RQ7]
  assign count_evt     = strobe_count || fast_tick;                         // [RQ10] [RQ11]

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      counter_value <= CYL_ZERO;
    end else if (zero_hold) begin
      counter_value <= CYL_ZERO;                                            // [RQ9] [RQ13]
    end else if (top_detect && !direction_up_n) begin
      counter_value <= CYL_ZERO;                                            // [RQ6] [RQ12] [RQ15]
    end else if (minus1_detect) begin
      counter_value <= CYL_TOP;                                             // [RQ8] [RQ15]
    end else if (count_evt) begin
      if (!direction_up_n) begin
        counter_value <= counter_value + CYL_ONE;                           // [RQ4] [RQ14]
      end else if (!direction_down_n) begin
        counter_value <= counter_value - CYL_ONE;                           // [RQ7] [RQ14]
      end
    end else if (lc_flag_reg) begin
      counter_value <= lc_load_reg ? CYL_TOP : CYL_ZERO;                    // [RQ15]
    end
  end

  // The flag is set by a detect and cleared by a seek strobe or a fast tick; set wins.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lc_flag_reg <= 1'b0;
      lc_load_reg <= 1'b0;
    end else if (!zero_hold && ((top_detect && !direction_up_n) || minus1_detect)) begin
      lc_flag_reg <= 1'b1;                                                  // [RQ6] [RQ8]
      lc_load_reg <= minus1_detect;
    end else if (seek_fire || fast_tick) begin
      lc_flag_reg <= 1'b0;                                                  // [RQ4] [RQ8] [RQ10]
    end
  end

  assign counter_value_o = counter_value;

  // ---------------------------------------------------------------------------
  // Fault detect and restore
  // ---------------------------------------------------------------------------
  logic bad_cyl_reg;
  logic seek_fail_reg;
  logic restore_n_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bad_cyl_reg <= 1'b0;
    end else if (!drive_s.addr_invalid_n) begin
      bad_cyl_reg <= 1'b1;                                                  // [RQ20]
    end else if (!zero_override_n) begin
      bad_cyl_reg <= 1'b0;                                                  // [RQ20]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      seek_fail_reg <= 1'b0;
      restore_n_reg <= 1'b1;
    end else begin
      seek_fail_reg <= ~drive_s.seek_fail_in_n;                             // [RQ21]
      restore_n_reg <= zero_override_n;                                     // [RQ13]
    end
  end

  assign bad_cylinder_lamp_o = bad_cyl_reg;
  assign seek_fail_lamp_o    = seek_fail_reg;
  assign restore_n_o         = restore_n_reg;

  // ---------------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_COUNTER_LSB +: CYL_W] = counter_value;
    status_word[ST_SRC_SEL_BIT]   = counter_source_sel;
    status_word[ST_LC_FLAG_BIT]   = lc_flag_reg;
    status_word[ST_LC_LOAD_BIT]   = lc_load_reg;
    status_word[ST_BAD_CYL_BIT]   = bad_cyl_reg;
    status_word[ST_SEEK_FAIL_BIT] = seek_fail_reg;
    status_word[ST_SRC_TRIG_BIT]  = ~source_trigger_n;
    status_word[ST_BUSY_BIT]      = (strobe_state_reg != ST_IDLE);
  end

endmodule

/* File: tb/cse_exerciser_assertions.sv */
// Concurrent checks on the seek exerciser pins.
`timescale 1ns/1ps
module cse_checker (
  input wire logic                  core_clk_i,
  input wire logic                  rst_n_i,
  input wire cse_pkg::cse_panel_t   panel_i,
  input wire cse_pkg::cse_drive_t   drive_i,
  input wire logic                  bus_strobe_n_o,
  input wire logic [7:0]            cyl_addr_o,
  input wire logic                  restore_n_o,
  input wire logic                  bad_cylinder_lamp_o,
  input wire logic                  seek_fail_lamp_o,
  input wire logic [7:0]            counter_value_o
);
  import cse_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_STROBE_CAUSE: assert property ($fell(bus_strobe_n_o) |-> !$past(drive_i.ready_n, 4)
    && $past(panel_i.run_switch, 4)) else $error("strobe without ready");
  AST_STEP_ADDR: assert property ($fell(bus_strobe_n_o) && panel_i.function_sel == CSE_MODE_STEP
    && panel_i.direction_switch |-> cyl_addr_o == $past(counter_value_o) && counter_value_o == cyl_addr_o + CYL_ONE)
    else $error("step address");
  AST_ADDR_HOLD: assert property ($changed(cyl_addr_o) |-> $fell(bus_strobe_n_o)) else $error("address moved");
  AST_TOP_WRAP: assert property (counter_value_o == CYL_TOP && $past(counter_value_o) == 8'hc9
    |=> counter_value_o == CYL_ZERO) else $error("no wrap");
  AST_MINUS_LOAD: assert property (counter_value_o == CYL_MINUS1 |=> counter_value_o == CYL_TOP)
    else $error("no load");
  AST_OSC_ZERO: assert property ((panel_i.function_sel == CSE_MODE_OSC)[*5] |-> counter_value_o == CYL_ZERO)
    else $error("osc count");
  AST_RTZ_HOLD: assert property (panel_i.return_to_zero_switch[*5] |-> !restore_n_o
    && counter_value_o == CYL_ZERO) else $error("zero override");
  AST_SEEK_LAMP: assert property (seek_fail_lamp_o == !$past(drive_i.seek_fail_in_n, 3))
    else $error("seek lamp");
  AST_BAD_SET: assert property (!$past(drive_i.addr_invalid_n, 3) |-> bad_cylinder_lamp_o)
    else $error("bad lamp set");
  AST_BAD_CLEAR: assert property ($fell(bad_cylinder_lamp_o) |-> $past(panel_i.return_to_zero_switch, 3))
    else $error("bad lamp clear");
  cover property ($fell(bus_strobe_n_o) && panel_i.function_sel == CSE_MODE_RAND);
  cover property (counter_value_o == CYL_MINUS1);
  cover property ($fell(bad_cylinder_lamp_o));
endmodule
bind cse_exerciser cse_checker u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .panel_i(panel_i),
  .drive_i(drive_i), .bus_strobe_n_o(bus_strobe_n_o), .cyl_addr_o(cyl_addr_o), .restore_n_o(restore_n_o),
  .bad_cylinder_lamp_o(bad_cylinder_lamp_o), .seek_fail_lamp_o(seek_fail_lamp_o), .counter_value_o(counter_value_o));

/* File: tb/cse_drive_model.sv */
// Drive positioner model that answers seek strobes.
`timescale 1ns/1ps
module cse_drive_model (
  input  wire logic       core_clk_i,
  input  wire logic       bus_strobe_n_i,
  input  wire logic [9:0] busy_i,
  output logic            ready_n_o = 1'b1
);
  logic [9:0] busy_reg = 10'h000;
  always @(posedge core_clk_i) begin
    if (!bus_strobe_n_i) begin
      ready_n_o <= 1'b1;
      busy_reg  <= busy_i;
    end else if (busy_reg != 10'h000) begin
      busy_reg <= busy_reg - 10'h001;
    end else begin
      ready_n_o <= 1'b0;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the cylinder seek exerciser.
`timescale 1ns/1ps
module testbench;
  import cse_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  cse_panel_t  panel = '{1'b0, 1'b1, CSE_MODE_STEP, 1'b1, 8'h55};
  logic        ai_n = 1'b1, sf_n = 1'b1, rd = 1'b0, wr = 1'b0, rdy_n, stb_n, rst_o, bad, sfl, wt;
  logic [7:0]  addr, cnt, prev;
  logic [7:0]  alt_e [3] = '{8'h00, 8'hca, 8'hc9};
  logic [4:0]  ba = 5'h00;
  logic [9:0]  busy = 10'h004;
  logic [31:0] wd = 32'h0, rdat, q;
  int          n_mismatch = 0, n_tests = 0;
  always #5 core_clk_i = ~core_clk_i;
  cse_exerciser dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .panel_i(panel), .drive_i({rdy_n, ai_n, sf_n}),
    .bus_strobe_n_o(stb_n), .cyl_addr_o(addr), .restore_n_o(rst_o), .bad_cylinder_lamp_o(bad),
    .seek_fail_lamp_o(sfl), .counter_value_o(cnt), .avs_address_i(ba), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wt));
  cse_drive_model drv (.core_clk_i(core_clk_i), .bus_strobe_n_i(stb_n), .busy_i(busy), .ready_n_o(rdy_n));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    ba <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin @(posedge core_clk_i); #1; end while (wt !== 1'b0);
    @(posedge core_clk_i);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic seek(input logic [7:0] e, input bit on);
    while (stb_n === 1'b0) begin @(posedge core_clk_i); #1; end
    do begin @(posedge core_clk_i); #1; end while (stb_n !== 1'b0);
    if (on) chk(addr, e);
  endtask
  task automatic mode(input cse_mode_t m, input logic dir);
    panel.run_switch <= 1'b0;
    repeat (30) @(posedge core_clk_i);
    panel.return_to_zero_switch <= 1'b1;
    panel.function_sel <= m;
    panel.direction_switch <= dir;
    repeat (10) @(posedge core_clk_i);
    panel.return_to_zero_switch <= 1'b0;
    panel.run_switch <= 1'b1;
  endtask
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b1, REG_PULSE_WIDTH, 32'h3);
    bus(1'b1, REG_READY_DELAY, 32'h2);
    bus(1'b1, REG_FAST_PERIOD, 32'h2);
    bus(1'b0, REG_PULSE_WIDTH, 32'h0);
    chk(q, 32'h3);
    bus(1'b0, 5'h1c, 32'h0);
    chk(q, 32'h0);
    chk(rst_o, 1'b0);
    panel.return_to_zero_switch <= 1'b0;
    ai_n <= 1'b0;
    sf_n <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk(sfl, 1'b1);
    ai_n <= 1'b1;
    sf_n <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk({rst_o, bad, sfl}, 3'h6);
    panel.return_to_zero_switch <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk(bad, 1'b0);
    mode(CSE_MODE_STEP, 1'b1);
    for (int i = 0; i < 210; i++) seek(8'(i % 202), 1'b1);
    mode(CSE_MODE_ALT, 1'b0);
    for (int i = 0; i < 3; i++) begin
      seek(8'h55, 1'b1);
      seek(alt_e[i], 1'b1);
    end
    mode(CSE_MODE_OSC, 1'b1);
    seek(8'h55, 1'b1);
    seek(8'h00, 1'b1);
    busy <= 10'h3ff;
    mode(CSE_MODE_RAND, 1'b1);
    seek(8'h00, 1'b0);
    prev = addr;
    repeat (3) begin
      seek(8'h00, 1'b0);
      chk(addr != prev + 8'h01 && addr <= CYL_TOP, 1'b1);
      prev = addr;
    end
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_mismatch++;
    print_verdict();
  end
endmodule
